// ===== inc/ppp_pkg.sv
package ppp_pkg;

    // Clock and entry timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int ENTRY_HOLD_NS = 10000;
    localparam int ENTRY_HOLD_CYC =
        (ENTRY_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Action bit coding for the load strobe
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD = 2'h2;

    // Command opcodes
    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [7:0] CMD_ERASE = 8'h80;
    localparam logic [7:0] CMD_WR_FUSE = 8'h40;
    localparam logic [7:0] CMD_WR_LOCK = 8'h20;
    localparam logic [7:0] CMD_WR_FLASH = 8'h10;
    localparam logic [7:0] CMD_WR_EE = 8'h11;
    localparam logic [7:0] CMD_RD_SIG = 8'h08;
    localparam logic [7:0] CMD_RD_FUSE = 8'h04;
    localparam logic [7:0] CMD_RD_FLASH = 8'h02;
    localparam logic [7:0] CMD_RD_EE = 8'h03;

    // Fuse and lock reset values, erased values
    localparam logic [7:0] FUSE_LO_RST = 8'h62;
    localparam logic [7:0] FUSE_HI_RST = 8'hd9;
    localparam logic [7:0] FUSE_EXT_RST = 8'hff;
    localparam logic [7:0] LOCK_RST = 8'hff;
    localparam int KEEP_EE_BIT = 3;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // Array geometry
    localparam int FLASH_AW = 14;
    localparam int FLASH_PAGE_W = 6;
    localparam int EE_AW = 10;
    localparam int EE_PAGE_W = 2;

    // Busy sequencer states
    typedef enum logic [2:0] {
        ST_IDLE, ST_FL_PAGE, ST_EE_PAGE, ST_FLUSH,
        ST_ER_FLASH, ST_ER_EE, ST_ER_LOCK, ST_SHORT
    } ppp_state_t;

endpackage

// ===== rtl/ppp_mem.sv
`timescale 1ns/10ps
module ppp_mem #(
    parameter int W = 16,
    parameter int AW = 6
) (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [W-1:0] wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [W-1:0] rdata_o
);
    logic [W-1:0] mem_r [0:(1<<AW)-1];

    // Write port
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_r[waddr_i] <= wdata_i;
        end
    end

    // Registered read port
    always_ff @(posedge clk_i) begin
        rdata_o <= mem_r[raddr_i];
    end
endmodule

// ===== rtl/ppp_port.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Entry pins must stay zero for 10us after high voltage to enter.
// - Programming mode ends when the high voltage on reset goes away.
// - Load strobe rising edge: 00 address, 01 data, 10 command, 11 nothing.
// - Byte select low picks low address or data byte, high picks high byte.
// - Command bytes decode as fixed opcodes, one-hot except no-op 00, EEPROM write 11 and EEPROM read 03.
// - Program strobe falling edge starts erase or write; ready drops until done.
// - Chip erase clears flash, EEPROM, then locks; fuses stay unchanged.
// - Programmed EEPROM-keep fuse makes chip erase skip the EEPROM.
// - Loaded command and address persist across operations.
// - Page latch rising edge stores loaded data at word from low address.
// - Low address bits pick word in page, upper bits pick the page.
// - Write-flash plus program strobe writes whole buffer to addressed page.
// - Loading the no-operation command clears internal write control.
// - EEPROM page write starts on program strobe with byte select low.
// - Read flash drives low or high word byte while output enable low.
// - Ready is low while an operation runs, high when idle in programming mode.
// - Data bus is driven only while output enable is low.
module ppp_port
    import ppp_pkg::*;
#(
    parameter logic [7:0] SIG_BYTE0 = 8'h11, // Arbitrary identity value
    parameter logic [7:0] SIG_BYTE1 = 8'h22, // Arbitrary identity value
    parameter logic [7:0] SIG_BYTE2 = 8'h33, // Arbitrary identity value
    parameter logic [7:0] CAL_BYTE = 8'h80
) (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic HV_ENTRY_I,
    input wire logic OE_N_I,
    input wire logic WR_N_I,
    input wire logic LOAD_STROBE_I,
    input wire logic PAGE_LATCH_PULSE_I,
    input wire logic ACTION_SEL_HI_I,
    input wire logic ACTION_SEL_LO_I,
    input wire logic BYTE_SELECT_LO_HI_I,
    input wire logic BYTE_SELECT_EXT_I,
    input wire logic [7:0] DATA_I,
    output logic [7:0] DATA_O,
    output logic DATA_OE_N_O,
    output logic READY_NOT_BUSY_O,
    output logic PROG_MODE_O
);
    import ppp_pkg::*;

    localparam logic [16:0] SYNC_RST = 17'h0c000;
    localparam logic [FLASH_AW-1:0] FL_PG_LAST =
        FLASH_AW'((1 << FLASH_PAGE_W) - 1);
    localparam logic [FLASH_AW-1:0] EE_PG_LAST =
        FLASH_AW'((1 << EE_PAGE_W) - 1);
    localparam logic [FLASH_AW-1:0] FL_LAST = FLASH_AW'((1 << FLASH_AW) - 1);
    localparam logic [FLASH_AW-1:0] EE_LAST = FLASH_AW'((1 << EE_AW) - 1);

    logic rst_a_r, rst_n_r;
    logic [16:0] sync1_r, sync2_r;
    logic hv, oe_n, wr_n, ls, pl, ax1, ax0, bs1, bs2;
    logic [7:0] din;
    logic ls_q_r, pl_q_r, wr_q_r;
    logic ls_rise, pl_rise, wr_fall, wr_go;
    logic in_mode_r, fail_r;
    logic [11:0] hold_cnt_r;
    logic [7:0] cmd_r, addr_lo_r, addr_hi_r, data_lo_r, data_hi_r;
    logic [7:0] fuse_lo_r, fuse_hi_r, fuse_ext_r, lock_r;
    ppp_state_t st_r;
    logic [FLASH_AW-1:0] idx_r, idx_d_r;
    logic wv_r, wee_r;
    logic [15:0] fl_word;
    logic buf_we, fl_we, ee_we;
    logic [FLASH_PAGE_W-1:0] buf_waddr;
    logic [15:0] buf_wdata, buf_rdata, fl_wdata, fl_rdata;
    logic [FLASH_AW-1:0] fl_waddr;
    logic [EE_AW-1:0] ee_waddr;
    logic [7:0] ee_wdata, ee_rdata, rd_byte;

    ////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers

    // Reset leaves through two flops
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rst_a_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_a_r <= 1'b1;
            rst_n_r <= rst_a_r;
        end
    end

    // Two flops on every pin; strobes idle high are reset high
    always_ff @(posedge CLK_I or negedge rst_n_r) begin
        if (!rst_n_r) begin
            sync1_r <= SYNC_RST;
            sync2_r <= SYNC_RST;
        end else begin
            sync1_r <= {HV_ENTRY_I, OE_N_I, WR_N_I, LOAD_STROBE_I,
                        PAGE_LATCH_PULSE_I, ACTION_SEL_HI_I, ACTION_SEL_LO_I,
                        BYTE_SELECT_LO_HI_I, BYTE_SELECT_EXT_I, DATA_I};
            sync2_r <= sync1_r;
        end
    end

    assign {hv, oe_n, wr_n, ls, pl, ax1, ax0, bs1, bs2, din} = sync2_r;

    // Edge history for strobes
    always_ff @(posedge CLK_I or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ls_q_r <= 1'b0;
            pl_q_r <= 1'b0;
            wr_q_r <= 1'b1;
        end else begin
            ls_q_r <= ls;
            pl_q_r <= pl;
            wr_q_r <= wr_n;
        end
    end

    // One event per pulse, only when idle in programming mode
    assign ls_rise = in_mode_r && st_r == ST_IDLE && ls && !ls_q_r;
    assign pl_rise = in_mode_r && st_r == ST_IDLE && pl && !pl_q_r;
    assign wr_fall = in_mode_r && st_r == ST_IDLE && !wr_n && wr_q_r;
    assign wr_go = wr_fall && (cmd_r == CMD_ERASE || cmd_r == CMD_WR_FUSE ||
        cmd_r == CMD_WR_LOCK || cmd_r == CMD_WR_FLASH ||
        (cmd_r == CMD_WR_EE && !bs1));

    ////////////////////////////////////////////////////////////////////////
    // Programming mode entry and exit

    // Entry pattern must read zero for the whole hold time
    always_ff @(posedge CLK_I or negedge rst_n_r) begin
        if (!rst_n_r) begin
            in_mode_r <= 1'b0;
            fail_r <= 1'b0;
            hold_cnt_r <= 12'h000;
        end else if (!hv) begin
            in_mode_r <= 1'b0;
            fail_r <= 1'b0;
            hold_cnt_r <= 12'h000;
        end else if (!in_mode_r && !fail_r) begin
            if ({pl, ax1, ax0, bs1} != 4'h0) begin
                fail_r <= 1'b1;
            end else if (hold_cnt_r == 12'(ENTRY_HOLD_CYC - 1)) begin
                in_mode_r <= 1'b1;
            end else begin
                hold_cnt_r <= hold_cnt_r + 12'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command, address and data latches

    // Loads decoded from the action bits; values persist between uses
    always_ff @(posedge CLK_I or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cmd_r <= CMD_NOP;
            addr_lo_r <= 8'h00;
            addr_hi_r <= 8'h00;
            data_lo_r <= 8'h00;
            data_hi_r <= 8'h00;
        end else if (!in_mode_r) begin
            cmd_r <= CMD_NOP;
        end else if (ls_rise) begin
            case ({ax1, ax0})
                ACT_ADDR: begin
                    if (bs1) begin
                        addr_hi_r <= din;
                    end else begin
                        addr_lo_r <= din;
                    end
                end
                ACT_DATA: begin
                    if (bs1) begin
                        data_hi_r <= din;
                    end else begin
                        data_lo_r <= din;
                    end
                end
                ACT_CMD: cmd_r <= din;
                default: ;
            endcase
        end
    end

    assign fl_word = {addr_hi_r, addr_lo_r};

    ////////////////////////////////////////////////////////////////////////
    // Busy sequencer

    // Page copies, chip erase passes and short fuse and lock writes
    always_ff @(posedge CLK_I or negedge rst_n_r) begin
        if (!rst_n_r) begin
            st_r <= ST_IDLE;
            idx_r <= '0;
        end else if (!in_mode_r) begin
            st_r <= ST_IDLE;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    idx_r <= '0;
                    if (wr_go) begin
                        case (cmd_r)
                            CMD_ERASE: st_r <= ST_ER_FLASH;
                            CMD_WR_FLASH: st_r <= ST_FL_PAGE;
                            CMD_WR_EE: st_r <= ST_EE_PAGE;
                            default: st_r <= ST_SHORT;
                        endcase
                    end
                end
                ST_FL_PAGE, ST_EE_PAGE: begin
                    idx_r <= idx_r + 1'b1;
                    if (idx_r == (st_r == ST_FL_PAGE ? FL_PG_LAST
                                                     : EE_PG_LAST)) begin
                        st_r <= ST_FLUSH;
                    end
                end
                ST_ER_FLASH: begin
                    idx_r <= idx_r + 1'b1;
                    if (idx_r == FL_LAST) begin
                        idx_r <= '0;
                        st_r <= fuse_hi_r[KEEP_EE_BIT] ? ST_ER_EE
                                                       : ST_ER_LOCK;
                    end
                end
                ST_ER_EE: begin
                    idx_r <= idx_r + 1'b1;
                    if (idx_r == EE_LAST) begin
                        st_r <= ST_ER_LOCK;
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // Buffer read is registered, so array writes trail by one cycle
    always_ff @(posedge CLK_I or negedge rst_n_r) begin
        if (!rst_n_r) begin
            wv_r <= 1'b0;
            wee_r <= 1'b0;
            idx_d_r <= '0;
        end else begin
            wv_r <= in_mode_r && (st_r == ST_FL_PAGE || st_r == ST_EE_PAGE);
            wee_r <= st_r == ST_EE_PAGE;
            idx_d_r <= idx_r;
        end
    end

    // Fuses keep their value through erase; locks only clear after flash
    always_ff @(posedge CLK_I or negedge rst_n_r) begin
        if (!rst_n_r) begin
            fuse_lo_r <= FUSE_LO_RST;
            fuse_hi_r <= FUSE_HI_RST;
            fuse_ext_r <= FUSE_EXT_RST;
            lock_r <= LOCK_RST;
        end else if (st_r == ST_ER_LOCK) begin
            lock_r <= ERASED_BYTE;
        end else if (wr_go && cmd_r == CMD_WR_LOCK) begin
            lock_r <= lock_r & data_lo_r;
        end else if (wr_go && cmd_r == CMD_WR_FUSE) begin
            case ({bs2, bs1})
                2'h0: fuse_lo_r <= data_lo_r;
                2'h1: fuse_hi_r <= data_lo_r;
                2'h2: fuse_ext_r <= data_lo_r;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Page buffer and arrays

    // Page latch stores the loaded word or byte at its slot
    assign buf_we = pl_rise && (cmd_r == CMD_WR_FLASH || cmd_r == CMD_WR_EE);
    assign buf_waddr = (cmd_r == CMD_WR_EE)
        ? {{(FLASH_PAGE_W-EE_PAGE_W){1'b0}}, addr_lo_r[EE_PAGE_W-1:0]}
        : addr_lo_r[FLASH_PAGE_W-1:0];
    assign buf_wdata = (cmd_r == CMD_WR_EE) ? {8'h00, data_lo_r}
                                            : {data_hi_r, data_lo_r};

    // Array write ports shared by page copy and erase
    always_comb begin
        fl_we = 1'b0;
        ee_we = 1'b0;
        fl_waddr = idx_r;
        ee_waddr = idx_r[EE_AW-1:0];
        fl_wdata = ERASED_WORD;
        ee_wdata = ERASED_BYTE;
        if (st_r == ST_ER_FLASH) begin
            fl_we = 1'b1;
        end else if (st_r == ST_ER_EE) begin
            ee_we = 1'b1;
        end else if (wv_r && !wee_r) begin
            fl_we = 1'b1;
            fl_waddr = {fl_word[FLASH_AW-1:FLASH_PAGE_W],
                        idx_d_r[FLASH_PAGE_W-1:0]};
            fl_wdata = buf_rdata;
        end else if (wv_r) begin
            ee_we = 1'b1;
            ee_waddr = {fl_word[EE_AW-1:EE_PAGE_W],
                        idx_d_r[EE_PAGE_W-1:0]};
            ee_wdata = buf_rdata[7:0];
        end
    end

    ppp_mem #(.W(16), .AW(FLASH_PAGE_W)) u_page_buf (
        .clk_i(CLK_I),
        .we_i(buf_we),
        .waddr_i(buf_waddr),
        .wdata_i(buf_wdata),
        .raddr_i(idx_r[FLASH_PAGE_W-1:0]),
        .rdata_o(buf_rdata)
    );

    ppp_mem #(.W(16), .AW(FLASH_AW)) u_flash (
        .clk_i(CLK_I),
        .we_i(fl_we),
        .waddr_i(fl_waddr),
        .wdata_i(fl_wdata),
        .raddr_i(fl_word[FLASH_AW-1:0]),
        .rdata_o(fl_rdata)
    );

    ppp_mem #(.W(8), .AW(EE_AW)) u_eeprom (
        .clk_i(CLK_I),
        .we_i(ee_we),
        .waddr_i(ee_waddr),
        .wdata_i(ee_wdata),
        .raddr_i(fl_word[EE_AW-1:0]),
        .rdata_o(ee_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read path and outputs

    // Byte selected by the loaded read command and the byte selects
    always_comb begin
        rd_byte = 8'h00;
        case (cmd_r)
            CMD_RD_FLASH: rd_byte = bs1 ? fl_rdata[15:8]
                                        : fl_rdata[7:0];
            CMD_RD_EE: rd_byte = ee_rdata;
            CMD_RD_FUSE: begin
                case ({bs2, bs1})
                    2'h0: rd_byte = fuse_lo_r;
                    2'h3: rd_byte = fuse_hi_r;
                    2'h2: rd_byte = fuse_ext_r;
                    default: rd_byte = lock_r;
                endcase
            end
            CMD_RD_SIG: begin
                if (bs1) begin
                    rd_byte = CAL_BYTE;
                end else if (addr_lo_r == 8'h00) begin
                    rd_byte = SIG_BYTE0;
                end else if (addr_lo_r == 8'h01) begin
                    rd_byte = SIG_BYTE1;
                end else if (addr_lo_r == 8'h02) begin
                    rd_byte = SIG_BYTE2;
                end
            end
            default: rd_byte = 8'h00;
        endcase
    end

    // All outputs registered
    always_ff @(posedge CLK_I or negedge rst_n_r) begin
        if (!rst_n_r) begin
            DATA_O <= 8'h00;
            DATA_OE_N_O <= 1'b1;
            READY_NOT_BUSY_O <= 1'b0;
            PROG_MODE_O <= 1'b0;
        end else begin
            DATA_O <= rd_byte;
            DATA_OE_N_O <= !(in_mode_r && !oe_n);
            READY_NOT_BUSY_O <= in_mode_r && st_r == ST_IDLE
                                && !wr_go;
            PROG_MODE_O <= in_mode_r;
        end
    end
endmodule

// ===== tb/parallel_program_port_bench.sv
`timescale 1ns/10ps
module parallel_program_port_bench;
    import ppp_pkg::*;
    typedef struct {
        logic [7:0] hi;
        logic [7:0] lo;
        logic [7:0] dlo;
        logic [7:0] dhi;
    } ppp_row_t;
    logic clk, rst_n, hv, oe_n, wr_n, ls, pl, a1, a0, bs1, bs2;
    logic dq_en, dev_oe_n, rdy, mode;
    logic [7:0] dq, dev_q, bus;
    int error_cnt, compares, n;
    ppp_row_t rows [3] = '{
        '{8'h01, 8'h80, 8'h34, 8'h12},
        '{8'h3f, 8'hff, 8'hcd, 8'hab},
        '{8'h00, 8'h00, 8'h00, 8'h5a}
    };

    // Shared data bus, released lines show the inverse
    assign bus = !dev_oe_n ? dev_q : (dq_en ? dq : ~dq);

    ppp_port #(.SIG_BYTE0(8'h5a), .CAL_BYTE(8'h3c)) uut (
        .CLK_I(clk), .RESET_N_I(rst_n), .HV_ENTRY_I(hv), .OE_N_I(oe_n),
        .WR_N_I(wr_n), .LOAD_STROBE_I(ls), .PAGE_LATCH_PULSE_I(pl),
        .ACTION_SEL_HI_I(a1), .ACTION_SEL_LO_I(a0),
        .BYTE_SELECT_LO_HI_I(bs1), .BYTE_SELECT_EXT_I(bs2), .DATA_I(bus),
        .DATA_O(dev_q), .DATA_OE_N_O(dev_oe_n), .READY_NOT_BUSY_O(rdy),
        .PROG_MODE_O(mode)
    );
    ppp_prog_model p (
        .clk_i(clk), .rdy_i(rdy), .dq_i(bus), .hv_o(hv), .oe_n_o(oe_n),
        .wr_n_o(wr_n), .ls_o(ls), .pl_o(pl), .sel_hi_o(a1), .sel_lo_o(a0),
        .bs1_o(bs1), .bs2_o(bs2), .dq_o(dq), .dq_en_o(dq_en)
    );

    // Clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Verdict and end of run
    task automatic finish_test();
        if (error_cnt == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Compare and report
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %s exp %h got %h", nm, e, g);
        end
    endtask

    // Command load and checked read
    task automatic cmd(input logic [7:0] c);
        p.load(ACT_CMD, 1'b0, c);
    endtask
    task automatic rdc(input logic b1, input logic b2, input logic [7:0] e,
                       input string nm);
        logic [7:0] v;
        p.rd(b1, b2, v);
        chk(nm, {8'h00, e}, {8'h00, v});
    endtask

    // Hang guard
    initial begin
        #600000;
        error_cnt++;
        finish_test();
    end

    // Main sequence
    initial begin
        error_cnt = 0;
        compares = 0;
        rst_n = 1'b0;
        repeat (4) @(negedge clk);
        chk("reset outs", 16'h0001, {13'h0, mode, rdy, dev_oe_n});
        @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        p.enter(4'h1);
        chk("bad entry", 16'h0000, {15'h0, mode});
        p.enter(4'h0);
        chk("entry", 16'h0003, {14'h0, mode, rdy});
        cmd(CMD_ERASE);
        p.prog(1'b0, 1'b0, n);
        chk("erase busy", 16'h0001, 16'(n > 17379 && n < 17431));
        foreach (rows[i]) begin
            cmd(CMD_WR_FLASH);
            p.load(ACT_ADDR, 1'b1, rows[i].hi);
            p.load(ACT_ADDR, 1'b0, rows[i].lo);
            p.load(ACT_DATA, 1'b0, rows[i].dlo);
            p.load(ACT_DATA, 1'b1, rows[i].dhi);
            p.latch();
            p.prog(1'b0, 1'b0, n);
            chk("page busy", 16'h0001, 16'(n > 49 && n < 71));
            cmd(CMD_RD_FLASH);
            rdc(1'b0, 1'b0, rows[i].dlo, "flash lo");
            rdc(1'b1, 1'b0, rows[i].dhi, "flash hi");
        end
        // Page bits, idle action, kept high address
        p.load(ACT_ADDR, 1'b1, 8'h01);
        p.load(ACT_ADDR, 1'b0, 8'h40);
        rdc(1'b0, 1'b0, ERASED_BYTE, "other page");
        p.load(2'h3, 1'b0, 8'h80);
        rdc(1'b0, 1'b0, ERASED_BYTE, "idle action");
        p.load(ACT_ADDR, 1'b0, 8'h80);
        rdc(1'b0, 1'b0, rows[0].dlo, "kept high");
        cmd(CMD_NOP);
        p.prog(1'b0, 1'b0, n);
        chk("nop strobe", 16'h0000, 16'(n));
        // EEPROM page write with two of its four bytes loaded
        cmd(CMD_WR_EE);
        p.load(ACT_ADDR, 1'b1, 8'h02);
        for (int k = 0; k < 2; k++) begin
            p.load(ACT_ADDR, 1'b0, 8'(8'h14 + k));
            p.load(ACT_DATA, 1'b0, 8'(8'ha0 + k));
            p.latch();
        end
        p.prog(1'b0, 1'b0, n);
        chk("ee busy", 16'h0001, 16'(n < 9));
        cmd(CMD_RD_EE);
        rdc(1'b0, 1'b0, 8'ha1, "ee byte");
        // Fuse with keep bit programmed, then lock
        cmd(CMD_WR_FUSE);
        p.load(ACT_DATA, 1'b0, 8'hd1);
        p.prog(1'b1, 1'b0, n);
        cmd(CMD_WR_LOCK);
        p.load(ACT_DATA, 1'b0, 8'hfc);
        p.prog(1'b0, 1'b0, n);
        cmd(CMD_RD_FUSE);
        rdc(1'b1, 1'b1, 8'hd1, "fuse hi");
        rdc(1'b1, 1'b0, 8'hfc, "lock");
        cmd(CMD_RD_SIG);
        p.load(ACT_ADDR, 1'b0, 8'h00);
        rdc(1'b0, 1'b0, 8'h5a, "signature");
        rdc(1'b1, 1'b0, 8'h3c, "calibration");
        // Erase keeping the EEPROM
        cmd(CMD_ERASE);
        p.prog(1'b0, 1'b0, n);
        chk("keep busy", 16'h0001, 16'(n > 16359 && n < 16401));
        cmd(CMD_RD_FUSE);
        rdc(1'b1, 1'b0, ERASED_BYTE, "lock erased");
        rdc(1'b1, 1'b1, 8'hd1, "fuse kept");
        rdc(1'b0, 1'b0, FUSE_LO_RST, "fuse lo");
        cmd(CMD_RD_EE);
        p.load(ACT_ADDR, 1'b1, 8'h02);
        p.load(ACT_ADDR, 1'b0, 8'h15);
        rdc(1'b0, 1'b0, 8'ha1, "ee kept");
        cmd(CMD_RD_FLASH);
        p.load(ACT_ADDR, 1'b1, 8'h01);
        p.load(ACT_ADDR, 1'b0, 8'h80);
        rdc(1'b0, 1'b0, ERASED_BYTE, "flash erased");
        p.leave();
        chk("exit", 16'h0000, {14'h0, mode, rdy});
        finish_test();
    end
endmodule

// ===== tb/ppp_port_sva.sv
`timescale 1ns/10ps
module ppp_port_sva
    import ppp_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic HV_ENTRY_I,
    input wire logic OE_N_I,
    input wire logic WR_N_I,
    input wire logic LOAD_STROBE_I,
    input wire logic PAGE_LATCH_PULSE_I,
    input wire logic ACTION_SEL_HI_I,
    input wire logic ACTION_SEL_LO_I,
    input wire logic BYTE_SELECT_LO_HI_I,
    input wire logic BYTE_SELECT_EXT_I,
    input wire logic [7:0] DATA_I,
    input wire logic [7:0] DATA_O,
    input wire logic DATA_OE_N_O,
    input wire logic READY_NOT_BUSY_O,
    input wire logic PROG_MODE_O
);
    int hv_cnt_r;
    int wr_age_r;
    int busy_r;
    logic wr_q_r;
    logic pat_nz;

    // Entry pattern pins not all zero
    assign pat_nz = |{PAGE_LATCH_PULSE_I, ACTION_SEL_HI_I, ACTION_SEL_LO_I,
                      BYTE_SELECT_LO_HI_I};

    // High voltage time with clean pattern, -1 marks a spoilt entry
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I || !HV_ENTRY_I) begin
            hv_cnt_r <= 0;
        end else if (hv_cnt_r < 0 ||
                     (pat_nz && hv_cnt_r < ENTRY_HOLD_CYC)) begin
            hv_cnt_r <= -1;
        end else if (hv_cnt_r < 4000) begin
            hv_cnt_r <= hv_cnt_r + 1;
        end
    end

    // Cycles since the program strobe last fell
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            wr_q_r <= 1'b1;
            wr_age_r <= 255;
        end else begin
            wr_q_r <= WR_N_I;
            if (wr_q_r && !WR_N_I) begin
                wr_age_r <= 0;
            end else if (wr_age_r < 255) begin
                wr_age_r <= wr_age_r + 1;
            end
        end
    end

    // Length of the present busy spell
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I || READY_NOT_BUSY_O || !PROG_MODE_O) begin
            busy_r <= 0;
        end else begin
            busy_r <= busy_r + 1;
        end
    end

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RESET_N_I);

    sequence hv_gone;
        !HV_ENTRY_I [*6];
    endsequence
    sequence oe_held;
        (PROG_MODE_O && !OE_N_I) [*8];
    endsequence

    a_entry_after_hold: assert property (
        $rose(PROG_MODE_O) |-> hv_cnt_r >= ENTRY_HOLD_CYC)
        else $error("mode entered without a clean hold");
    a_ready_on_entry: assert property (
        $rose(PROG_MODE_O) |-> ##[0:1] READY_NOT_BUSY_O)
        else $error("not ready after entry");
    a_exit_on_drop: assert property (
        hv_gone |-> !PROG_MODE_O)
        else $error("mode kept without high voltage");
    a_idle_stays_quiet: assert property (
        !PROG_MODE_O [*4] |-> !READY_NOT_BUSY_O && DATA_OE_N_O)
        else $error("outputs active outside mode");
    a_bus_released: assert property (
        OE_N_I [*6] |-> DATA_OE_N_O)
        else $error("bus driven without output enable");
    a_bus_driven: assert property (
        oe_held |-> !DATA_OE_N_O)
        else $error("bus not driven with output enable");
    a_busy_from_strobe: assert property (
        $fell(READY_NOT_BUSY_O) && PROG_MODE_O && hv_cnt_r > 8
        |-> wr_age_r <= 8)
        else $error("busy without program strobe");
    a_busy_bounded: assert property (
        busy_r < 17500)
        else $error("busy spell too long");
endmodule

bind ppp_port ppp_port_sva sva_i (
    .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .HV_ENTRY_I(HV_ENTRY_I),
    .OE_N_I(OE_N_I), .WR_N_I(WR_N_I), .LOAD_STROBE_I(LOAD_STROBE_I),
    .PAGE_LATCH_PULSE_I(PAGE_LATCH_PULSE_I),
    .ACTION_SEL_HI_I(ACTION_SEL_HI_I), .ACTION_SEL_LO_I(ACTION_SEL_LO_I),
    .BYTE_SELECT_LO_HI_I(BYTE_SELECT_LO_HI_I),
    .BYTE_SELECT_EXT_I(BYTE_SELECT_EXT_I), .DATA_I(DATA_I),
    .DATA_O(DATA_O), .DATA_OE_N_O(DATA_OE_N_O),
    .READY_NOT_BUSY_O(READY_NOT_BUSY_O), .PROG_MODE_O(PROG_MODE_O)
);

// ===== tb/ppp_prog_model.sv
`timescale 1ns/10ps
module ppp_prog_model
    import ppp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rdy_i,
    input wire logic [7:0] dq_i,
    output logic hv_o,
    output logic oe_n_o,
    output logic wr_n_o,
    output logic ls_o,
    output logic pl_o,
    output logic sel_hi_o,
    output logic sel_lo_o,
    output logic bs1_o,
    output logic bs2_o,
    output logic [7:0] dq_o,
    output logic dq_en_o
);
    // Idle levels, entry pattern all zero
    initial begin
        {hv_o, ls_o, pl_o, sel_hi_o, sel_lo_o, bs1_o, bs2_o} = 7'h00;
        {oe_n_o, wr_n_o, dq_o, dq_en_o} = {2'h3, 8'h00, 1'b0};
    end

    // Wait on falling edges
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // High voltage with pattern held through the latch window
    task automatic enter(input logic [3:0] pat);
        hv_o = 1'b0;
        {pl_o, sel_hi_o, sel_lo_o, bs1_o} = pat;
        cyc(4);
        hv_o = 1'b1;
        cyc(ENTRY_HOLD_CYC + 20);
        if (pat == 4'h0)
            cyc(300000000 / CLK_PERIOD_PS);
    endtask

    // Drop the high voltage
    task automatic leave();
        hv_o = 1'b0;
        cyc(8);
    endtask

    // One load strobe pulse, selects and data held around it
    task automatic load(input logic [1:0] act, input logic b1,
                        input logic [7:0] d);
        {sel_hi_o, sel_lo_o, bs1_o, bs2_o} = {act, b1, 1'b0};
        {dq_o, dq_en_o} = {d, 1'b1};
        cyc(4);
        ls_o = 1'b1;
        cyc(4);
        ls_o = 1'b0;
        cyc(3);
        dq_en_o = 1'b0;
        cyc(1);
    endtask

    // Page latch pulse
    task automatic latch();
        pl_o = 1'b1;
        cyc(4);
        pl_o = 1'b0;
        cyc(4);
    endtask

    // Program strobe, then wait out the busy spell
    task automatic prog(input logic b1, input logic b2, output int n);
        {bs1_o, bs2_o} = {b1, b2};
        cyc(4);
        wr_n_o = 1'b0;
        cyc(4);
        wr_n_o = 1'b1;
        cyc(4);
        for (n = 0; n < 30000 && rdy_i !== 1'b1; n++) begin
            cyc(1);
        end
        {bs1_o, bs2_o} = 2'h0;
        cyc(1);
    endtask

    // Read one byte with output enable low
    task automatic rd(input logic b1, input logic b2,
                      output logic [7:0] v);
        {bs1_o, bs2_o, oe_n_o} = {b1, b2, 1'b0};
        cyc(10);
        v = dq_i;
        oe_n_o = 1'b1;
        cyc(6);
    endtask
endmodule
